// *** design/rc_meas_if.sv ***
// Measurement results of one pulse channel
`timescale 1ns/1ps
interface rc_meas_if;
	logic [15:0] width;
	logic strobe;
	logic fresh;
	modport src (output width, output strobe, output fresh);
	modport dst (input width, input strobe, input fresh);
endinterface : rc_meas_if

// *** design/rc_pkg.sv ***
// Shared constants and types of the radio pulse capture and watchdog block
package rc_pkg;
	localparam int CLK_HZ = 20_000_000;
	localparam int US_PER_S = 1_000_000;
	localparam int CYC_PER_US = CLK_HZ / US_PER_S;
	// Nominal pulse widths in microseconds
	localparam int PW_MIN_US = 1000;
	localparam int PW_CTR_US = 1500;
	localparam int PW_MAX_US = 2000;
	// Acceptance window for a pulse to count as genuine
	localparam int PW_LO_US = 800;
	localparam int PW_HI_US = 2500;
	// Watchdog intervals in microseconds
	localparam int GAP_US = 30000;
	localparam int ARM_US = 500000;
	localparam int GRACE_US = 250000;
	localparam int GAP_CYC = GAP_US * CYC_PER_US;
	localparam int ARM_CYC = ARM_US * CYC_PER_US;
	localparam int GRACE_CYC = GRACE_US * CYC_PER_US;
	localparam int PW_LO_CYC = PW_LO_US * CYC_PER_US;
	localparam int PW_HI_CYC = PW_HI_US * CYC_PER_US;
	localparam int WIDTH_W = 16;
	// Reference reset values in clock cycles
	localparam logic [15:0] REF_MIN_RST = 16'(PW_MIN_US * CYC_PER_US);
	localparam logic [15:0] REF_CTR_RST = 16'(PW_CTR_US * CYC_PER_US);
	localparam logic [15:0] REF_MAX_RST = 16'(PW_MAX_US * CYC_PER_US);
	// Reference slot selectors
	localparam logic [1:0] REF_SEL_MIN = 2'h0;
	localparam logic [1:0] REF_SEL_CTR = 2'h1;
	localparam logic [1:0] REF_SEL_MAX = 2'h2;
	localparam int CMD_FULL = 127;
	localparam logic signed [7:0] ACC_THR = 8'sh40;
	typedef enum logic [1:0] {
		ST_NO_LINK = 2'b00,
		ST_ARM = 2'b01,
		ST_RUN = 2'b10,
		ST_GRACE = 2'b11
	} link_state_e;
endpackage : rc_pkg

// *** design/rc_pulse_capture_watchdog.sv ***
// Radio pulse capture, command conversion, reception watchdog and accessories
`timescale 1ns/1ps
module rc_pulse_capture_watchdog
	import rc_pkg::*;
#(
	parameter int GAP_LIMIT = GAP_CYC,
	parameter int ARM_LIMIT = ARM_CYC,
	parameter int GRACE_LIMIT = GRACE_CYC
) (
	input wire logic i_core_clk, // Core clock, 20 MHz
	input wire logic i_nrst, // Async reset, active low
	input wire logic i_radio_pulse_in_first, // Channel one pulses
	input wire logic i_radio_pulse_in_second, // Channel two pulses
	input wire logic i_radio_pulse_in_third, // Channel three pulses
	input wire logic i_encoder_fitted, // Encoder module present
	input wire logic i_mixed_mode, // 1 mixed steering, 0 separate
	input wire logic i_buttons_both, // Both front buttons held
	input wire logic i_mode_wr, // Input mode write strobe
	input wire logic i_mode_pulse, // Value: 1 selects pulse input mode
	input wire logic i_ref_wr, // Reference write strobe
	input wire logic [1:0] i_ref_chan, // Reference channel 0..2
	input wire logic [1:0] i_ref_sel, // Min, centre or max slot
	input wire logic [15:0] i_ref_val, // Reference width in cycles
	input wire logic i_ref_persist, // Also store as new default
	output logic o_motor_en, // Motors enabled
	output logic signed [7:0] o_cmd_first, // Motor one command
	output logic signed [7:0] o_cmd_second, // Motor two command
	output logic [1:0] o_acc_out, // Accessory outputs
	output logic o_disp_no_ctrl, // Scroll no-control message
	output logic [1:0] o_disp_dir, // Direction per motor, 1 reverse
	output logic o_disp_flash, // Restore confirmation flash
	output logic o_nv_wr, // Store reference in non-volatile memory
	output logic [1:0] o_nv_chan, // Stored reference channel
	output logic [1:0] o_nv_sel, // Stored reference slot
	output logic [15:0] o_nv_val, // Stored reference value
	output logic o_nv_restore // Restore factory defaults in storage
);
	link_state_e state_ff;
	link_state_e nxt_state;
	logic [31:0] timer_ff;
	logic [31:0] nxt_timer;
	logic [15:0] ref_ff [3][3];
	logic signed [7:0] cmd_ff [3];
	logic [2:0] fresh;
	logic [2:0] pin_vec;
	logic link_ok;
	logic en_state;
	logic mode_pulse_ff;
	logic boot_done_ff;
	logic restore;

	rc_meas_if meas [3] ();

	// Signed command from width and three references
	function automatic logic signed [7:0] to_cmd(input logic [15:0] w, input logic [15:0] mn,
			input logic [15:0] ct, input logic [15:0] mx);
		logic [31:0] d;
		logic [31:0] span;
		logic [31:0] q;
		d = 32'h0;
		span = 32'h0;
		if (w >= ct) begin
			d = 32'(w - ct);
			span = (mx > ct) ? 32'(mx - ct) : 32'h1;
		end else begin
			d = 32'(ct - w);
			span = (ct > mn) ? 32'(ct - mn) : 32'h1;
		end
		q = (d * 32'(CMD_FULL)) / span;
		if (q > 32'(CMD_FULL)) begin
			q = 32'(CMD_FULL);
		end
		to_cmd = (w >= ct) ? 8'(q) : -8'(q);
	endfunction : to_cmd

	////////////////////////////////////////////////////////////////////
	// Third channel unavailable with encoder fitted
	assign pin_vec = {i_radio_pulse_in_third && !i_encoder_fitted,
		i_radio_pulse_in_second, i_radio_pulse_in_first};

	for (genvar g = 0; g < 3; g++) begin : g_chan
		rc_pulse_meas #(
			.GAP_LIMIT(GAP_LIMIT),
			.LO_LIMIT(PW_LO_CYC),
			.HI_LIMIT(PW_HI_CYC)
		) u_meas (
			.i_core_clk(i_core_clk),
			.i_nrst(i_nrst),
			.i_pulse(pin_vec[g]),
			.m(meas[g])
		);

		assign fresh[g] = meas[g].fresh;

		always_ff @(posedge i_core_clk or negedge i_nrst) begin
			if (!i_nrst) begin
				cmd_ff[g] <= 8'sh00;
			end else if (meas[g].strobe) begin
				cmd_ff[g] <= to_cmd(meas[g].width, ref_ff[g][0],
					ref_ff[g][1], ref_ff[g][2]);
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Power-up strap of both buttons
	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			boot_done_ff <= 1'b0;
		end else begin
			boot_done_ff <= 1'b1;
		end
	end

	assign restore = !boot_done_ff && i_buttons_both;

	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_disp_flash <= 1'b0;
			o_nv_restore <= 1'b0;
		end else begin
			o_nv_restore <= restore;
			if (restore) begin
				o_disp_flash <= 1'b1;
			end else if (!i_buttons_both) begin
				o_disp_flash <= 1'b0;
			end
		end
	end

	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			mode_pulse_ff <= 1'b1;
		end else if (restore) begin
			mode_pulse_ff <= 1'b1;
		end else if (i_mode_wr) begin
			mode_pulse_ff <= i_mode_pulse;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Reference table, loaded from storage or calibration
	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			for (int c = 0; c < 3; c++) begin
				ref_ff[c][0] <= REF_MIN_RST;
				ref_ff[c][1] <= REF_CTR_RST;
				ref_ff[c][2] <= REF_MAX_RST;
			end
		end else if (restore) begin
			for (int c = 0; c < 3; c++) begin
				ref_ff[c][0] <= REF_MIN_RST;
				ref_ff[c][1] <= REF_CTR_RST;
				ref_ff[c][2] <= REF_MAX_RST;
			end
		end else if (i_ref_wr && i_ref_chan != 2'h3 && i_ref_sel != 2'h3) begin
			ref_ff[i_ref_chan][i_ref_sel] <= i_ref_val;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_nv_wr <= 1'b0;
			o_nv_chan <= 2'h0;
			o_nv_sel <= 2'h0;
			o_nv_val <= 16'h0000;
		end else begin
			o_nv_wr <= i_ref_wr && i_ref_persist && !restore && i_ref_chan != 2'h3
				&& i_ref_sel != 2'h3;
			if (i_ref_wr) begin
				o_nv_chan <= i_ref_chan;
				o_nv_sel <= i_ref_sel;
				o_nv_val <= i_ref_val;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Reception watchdog
	assign link_ok = i_mixed_mode ? (fresh[0] && fresh[1]) : (fresh[0] || fresh[1]);

	always_comb begin
		nxt_state = state_ff;
		nxt_timer = timer_ff + 32'h0000_0001;
		unique case (state_ff)
			ST_NO_LINK: begin
				nxt_timer = 32'h0000_0000;
				if (link_ok) begin
					nxt_state = ST_ARM;
				end
			end
			ST_ARM: begin
				if (!link_ok) begin
					nxt_state = ST_NO_LINK;
				end else if (timer_ff >= 32'(ARM_LIMIT) - 32'h1) begin
					nxt_state = ST_RUN;
				end
			end
			ST_RUN: begin
				nxt_timer = 32'h0000_0000;
				if (!link_ok) begin
					nxt_state = ST_GRACE;
				end
			end
			ST_GRACE: begin
				if (link_ok) begin
					nxt_state = ST_RUN;
				end else if (timer_ff >= 32'(GRACE_LIMIT) - 32'h1) begin
					nxt_state = ST_NO_LINK;
				end
			end
		endcase
		if (!mode_pulse_ff) begin
			nxt_state = ST_NO_LINK;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			state_ff <= ST_NO_LINK;
			timer_ff <= 32'h0000_0000;
		end else begin
			state_ff <= nxt_state;
			timer_ff <= nxt_timer;
		end
	end

	assign en_state = (state_ff == ST_RUN) || (state_ff == ST_GRACE);

	////////////////////////////////////////////////////////////////////
	// Motor commands and display
	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_motor_en <= 1'b0;
			o_cmd_first <= 8'sh00;
			o_cmd_second <= 8'sh00;
			o_disp_no_ctrl <= 1'b1;
			o_disp_dir <= 2'h0;
		end else begin
			o_motor_en <= en_state;
			o_cmd_first <= en_state ? cmd_ff[0] : 8'sh00;
			o_cmd_second <= en_state ? cmd_ff[1] : 8'sh00;
			o_disp_no_ctrl <= !en_state;
			o_disp_dir <= en_state ? {cmd_ff[1][7], cmd_ff[0][7]} : 2'h0;
		end
	end

	// Accessories follow channel three, off on loss
	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_acc_out <= 2'h0;
		end else if (!en_state || i_encoder_fitted || !fresh[2]) begin
			o_acc_out <= 2'h0;
		end else begin
			o_acc_out <= {cmd_ff[2] < -ACC_THR, cmd_ff[2] > ACC_THR};
		end
	end

	////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_nrst);

	AST_NO_LINK_MOTORS_OFF: assert property (state_ff == ST_NO_LINK |=> !o_motor_en)
		else $error("motors enabled without link");
	AST_ENABLE_ONLY_AFTER_ARM: assert property ($rose(o_motor_en) |->
		$past(state_ff, 2) == ST_ARM && $past(timer_ff, 2) >= 32'(ARM_LIMIT) - 32'h1)
		else $error("motors enabled without full arming interval");
	AST_GRACE_ENTRY: assert property (state_ff == ST_RUN && !link_ok && mode_pulse_ff
		|=> state_ff == ST_GRACE ##1 o_motor_en)
		else $error("motors not held during grace");
	AST_GRACE_RESUME: assert property (state_ff == ST_GRACE && link_ok && mode_pulse_ff
		|=> state_ff == ST_RUN)
		else $error("resumed pulses did not restore run");
	AST_GRACE_EXPIRE: assert property (state_ff == ST_GRACE && !link_ok
		&& timer_ff >= 32'(GRACE_LIMIT) - 32'h1 |=> state_ff == ST_NO_LINK ##1 o_disp_no_ctrl)
		else $error("grace expiry did not drop link");
	AST_ACC_OFF_ON_LOSS: assert property (!en_state |=> o_acc_out == 2'h0)
		else $error("accessory on without link");
	AST_ENCODER_BLOCKS_CH3: assert property (i_encoder_fitted |=> o_acc_out == 2'h0)
		else $error("third channel active with encoder");
	AST_MIXED_NEEDS_BOTH: assert property ((state_ff == ST_NO_LINK || state_ff == ST_ARM)
		&& i_mixed_mode && !(fresh[0] && fresh[1]) |=> state_ff == ST_NO_LINK)
		else $error("mixed mode armed on one channel");
	AST_CENTRE_IS_ZERO: assert property (meas[0].strobe && meas[0].width == ref_ff[0][1]
		|=> cmd_ff[0] == 8'sh00)
		else $error("centre width not zero command");
	AST_MAX_IS_FULL: assert property (meas[0].strobe && meas[0].width >= ref_ff[0][2]
		&& ref_ff[0][2] > ref_ff[0][1] |=> cmd_ff[0] == 8'sh7F)
		else $error("maximum width not full command");
	AST_RESTORE_MODE: assert property (restore |=> mode_pulse_ff && o_disp_flash)
		else $error("restore did not select pulse mode");
	AST_PERSIST_WRITE: assert property (i_ref_wr && i_ref_persist && !restore
		&& i_ref_chan != 2'h3 && i_ref_sel != 2'h3 |=> o_nv_wr && o_nv_val == $past(i_ref_val)
		&& o_nv_sel == $past(i_ref_sel) && o_nv_chan == $past(i_ref_chan))
		else $error("persistent reference not stored");

	COV_RUN: cover property (state_ff == ST_ARM ##1 state_ff == ST_RUN);
	COV_GRACE_RESUME: cover property (state_ff == ST_GRACE ##1 state_ff == ST_RUN);
	COV_GRACE_LOSS: cover property (state_ff == ST_GRACE ##1 state_ff == ST_NO_LINK);
	COV_ACC_ON: cover property (o_acc_out != 2'h0);
endmodule : rc_pulse_capture_watchdog

// *** design/rc_pulse_meas.sv ***
// High-time measurement and freshness tracking of one pulse input
`timescale 1ns/1ps
module rc_pulse_meas
	import rc_pkg::*;
#(
	parameter int GAP_LIMIT = GAP_CYC,
	parameter int LO_LIMIT = PW_LO_CYC,
	parameter int HI_LIMIT = PW_HI_CYC
) (
	input wire logic i_core_clk, // Core clock
	input wire logic i_nrst, // Async reset, active low
	input wire logic i_pulse, // Raw pulse input
	rc_meas_if.src m // Measurement results
);
	logic sync1_ff;
	logic sync2_ff;
	logic prev_ff;
	logic [15:0] cnt_ff;
	logic [31:0] gap_ff;
	logic fall;
	logic good;

	////////////////////////////////////////////////////////////////////
	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			sync1_ff <= 1'b0;
			sync2_ff <= 1'b0;
			prev_ff <= 1'b0;
		end else begin
			sync1_ff <= i_pulse;
			sync2_ff <= sync1_ff;
			prev_ff <= sync2_ff;
		end
	end

	assign fall = prev_ff && !sync2_ff;
	assign good = fall && (int'(cnt_ff) >= LO_LIMIT) && (int'(cnt_ff) <= HI_LIMIT);

	// High time in 50 ns steps, saturating
	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			cnt_ff <= 16'h0000;
		end else if (!sync2_ff) begin
			cnt_ff <= 16'h0000;
		end else if (cnt_ff != 16'hFFFF) begin
			cnt_ff <= cnt_ff + 16'h0001;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			m.width <= 16'h0000;
			m.strobe <= 1'b0;
		end else begin
			m.strobe <= good;
			if (good) begin
				m.width <= cnt_ff;
			end
		end
	end

	// Cycles since the last genuine pulse
	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			gap_ff <= 32'(GAP_LIMIT);
			m.fresh <= 1'b0;
		end else begin
			if (good) begin
				gap_ff <= 32'h0000_0000;
			end else if (gap_ff < 32'(GAP_LIMIT)) begin
				gap_ff <= gap_ff + 32'h0000_0001;
			end
			m.fresh <= good || (gap_ff < 32'(GAP_LIMIT) - 32'h0000_0001);
		end
	end

	////////////////////////////////////////////////////////////////////
	AST_STROBE_AFTER_FALL: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
		m.strobe |-> $past(prev_ff) && !$past(sync2_ff))
		else $error("width strobe without a falling edge");
	AST_WIDTH_IN_WINDOW: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
		m.strobe |-> int'(m.width) >= LO_LIMIT && int'(m.width) <= HI_LIMIT)
		else $error("accepted width outside window");
endmodule : rc_pulse_meas

// *** tb/rc_receiver_model.sv ***
// Radio receiver model that sends command pulses on one channel
`timescale 1ns/1ps
module rc_receiver_model (
	input wire logic i_clk, // Clock that times the pulses
	output logic o_pulse // Pulse line, driven low when idle
);
	initial o_pulse = 1'b0;
	// One pulse of w cycles, then g idle cycles; the line is always driven
	task automatic send(input int w, input int g);
		@(negedge i_clk);
		o_pulse = 1'b1;
		repeat (w) @(negedge i_clk);
		o_pulse = 1'b0;
		repeat (g) @(negedge i_clk);
	endtask : send
endmodule : rc_receiver_model

// *** tb/tb_rc_pulse_capture_watchdog.sv ***
// Testbench of the radio pulse capture and reception watchdog
`timescale 1ns/1ps
module tb_rc_pulse_capture_watchdog;
	import rc_pkg::*;
	// Shortened watchdog counts; gap and grace must exceed one pulse period
	localparam int GAP = 45000;
	localparam int ARM = 400;
	localparam int GRACE = 50000;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic enc = 1'b0;
	logic mixed = 1'b0;
	logic btn = 1'b0;
	logic mode_wr = 1'b0;
	logic mode_val = 1'b1;
	logic ref_wr = 1'b0;
	logic persist = 1'b0;
	logic [1:0] ref_chan = 2'h0;
	logic [1:0] ref_sel = 2'h0;
	logic [15:0] ref_val = 16'h0000;
	logic p1, p2, p3, motor_en, no_ctrl, flash, nv_wr, nv_restore;
	logic signed [7:0] cmd1, cmd2;
	logic [1:0] acc, dir, nv_chan, nv_sel;
	logic [15:0] nv_val;
	logic drop_seen = 1'b0;
	logic restore_seen = 1'b0;
	int err_count = 0;
	int tests_run = 0;

	always #25 clk = ~clk;
	always @(negedge motor_en) drop_seen = 1'b1;
	always @(posedge clk) if (nv_restore === 1'b1) restore_seen <= 1'b1;

	rc_receiver_model rx1 (.i_clk(clk), .o_pulse(p1));
	rc_receiver_model rx2 (.i_clk(clk), .o_pulse(p2));
	rc_receiver_model rx3 (.i_clk(clk), .o_pulse(p3));

	rc_pulse_capture_watchdog #(.GAP_LIMIT(GAP), .ARM_LIMIT(ARM), .GRACE_LIMIT(GRACE)) DUT (
		.i_core_clk(clk), .i_nrst(nrst), .i_radio_pulse_in_first(p1),
		.i_radio_pulse_in_second(p2), .i_radio_pulse_in_third(p3), .i_encoder_fitted(enc),
		.i_mixed_mode(mixed), .i_buttons_both(btn), .i_mode_wr(mode_wr),
		.i_mode_pulse(mode_val), .i_ref_wr(ref_wr), .i_ref_chan(ref_chan),
		.i_ref_sel(ref_sel), .i_ref_val(ref_val), .i_ref_persist(persist),
		.o_motor_en(motor_en), .o_cmd_first(cmd1), .o_cmd_second(cmd2), .o_acc_out(acc),
		.o_disp_no_ctrl(no_ctrl), .o_disp_dir(dir), .o_disp_flash(flash), .o_nv_wr(nv_wr),
		.o_nv_chan(nv_chan), .o_nv_sel(nv_sel), .o_nv_val(nv_val), .o_nv_restore(nv_restore)
	);

	////////////////////////////////////////////////////////////////////////////
	task automatic test_done;
		$display("Checks run %0d, mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : test_done

	task automatic check(input logic ok, input string msg);
		tests_run++;
		if (ok !== 1'b1) begin
			err_count++;
			$display("FAIL %0t %s", $time, msg);
		end
	endtask : check

	task automatic wait_motor(input logic v, input int lim);
		int n;
		n = 0;
		while (motor_en !== v && n < lim) begin
			@(negedge clk);
			n++;
		end
		check(motor_en === v, "motor enable did not reach expected level");
	endtask : wait_motor

	task automatic do_reset(input logic b);
		btn = b;
		nrst = 1'b0;
		repeat (10) @(negedge clk);
		nrst = 1'b1;
		repeat (3) @(negedge clk);
	endtask : do_reset

	task automatic do_ref(input logic [1:0] c, input logic [1:0] s, input logic [15:0] v,
		input logic p);
		ref_chan = c;
		ref_sel = s;
		ref_val = v;
		persist = p;
		ref_wr = 1'b1;
		@(negedge clk);
		ref_wr = 1'b0;
		check(nv_wr === p, "store strobe wrong");
	endtask : do_ref

	////////////////////////////////////////////////////////////////////////////
	task automatic t_idle;
		repeat (100) @(negedge clk);
		check(no_ctrl === 1'b1 && motor_en === 1'b0, "idle enable state");
		check(cmd1 === 8'sh00 && acc === 2'h0, "idle outputs not zero");
		check(restore_seen === 1'b0 && flash === 1'b0, "restore without buttons");
	endtask : t_idle

	task automatic t_arm;
		rx1.send(30000, 0);
		check(motor_en === 1'b0, "enabled before regular train seen");
		wait_motor(1'b1, ARM + 20);
		repeat (3) @(negedge clk);
		check(no_ctrl === 1'b0, "no-control still shown");
	endtask : t_arm

	task automatic t_cmd;
		logic signed [7:0] want [3];
		int w [3];
		want = '{8'sh81, 8'sh00, 8'sh7F};
		w = '{20000, 30000, 40000};
		for (int i = 0; i < 3; i++) begin
			rx1.send(w[i], 10);
			check(cmd1 === want[i], "channel one command");
			check(dir[0] === want[i][7], "direction of motor one");
		end
		rx1.send(30080, 10);
		check(cmd1 > 8'sh00, "small width step lost");
		fork
			rx1.send(30000, 10);
			rx2.send(20000, 10);
		join
		check(cmd2 === 8'sh81 && dir[1] === 1'b1, "channel two command");
	endtask : t_cmd

	task automatic t_ref;
		do_ref(2'h0, REF_SEL_MAX, 16'h8CA0, 1'b1);
		check(nv_chan === 2'h0 && nv_sel === REF_SEL_MAX && nv_val === 16'h8CA0, "stored");
		rx1.send(36000, 10);
		check(cmd1 === 8'sh7F, "new maximum reference unused");
		do_ref(2'h0, REF_SEL_MAX, 16'h9C40, 1'b0);
		// Width between the two maxima tells the old reference from the new
		rx1.send(38000, 10);
		check(cmd1 === 8'sh65, "maximum reference not restored");
	endtask : t_ref

	task automatic t_acc;
		fork
			rx1.send(30000, 10);
			rx3.send(40000, 10);
		join
		check(acc === 2'h1, "first accessory not on");
		fork
			rx1.send(30000, 10);
			rx3.send(20000, 10);
		join
		check(acc === 2'h2, "second accessory not on");
		enc = 1'b1;
		repeat (5) @(negedge clk);
		check(acc === 2'h0, "third channel used with encoder");
		enc = 1'b0;
	endtask : t_acc

	task automatic t_grace;
		drop_seen = 1'b0;
		repeat (GAP + 2000) @(negedge clk);
		check(motor_en === 1'b1, "disabled without grace");
		rx1.send(30000, 10);
		check(drop_seen === 1'b0 && motor_en === 1'b1, "control interrupted");
	endtask : t_grace

	task automatic t_loss;
		int n;
		n = 0;
		// Channel three keeps pulsing so only the loss can clear the accessories
		while (motor_en === 1'b1 && n < 5) begin
			rx3.send(40000, 10);
			n++;
		end
		check(motor_en === 1'b0, "link loss not detected");
		check(no_ctrl === 1'b1 && cmd1 === 8'sh00, "no-control not shown");
		check(acc === 2'h0, "accessory on after loss");
	endtask : t_loss

	task automatic t_mixed;
		mixed = 1'b1;
		rx1.send(30000, 10);
		rx1.send(30000, 10);
		check(motor_en === 1'b0, "mixed mode enabled on one channel");
		fork
			rx1.send(30000, 0);
			rx2.send(30000, 0);
		join
		wait_motor(1'b1, ARM + 20);
		mode_val = 1'b0;
		mode_wr = 1'b1;
		@(negedge clk);
		mode_wr = 1'b0;
		wait_motor(1'b0, 10);
		mode_val = 1'b1;
		mode_wr = 1'b1;
		@(negedge clk);
		mode_wr = 1'b0;
	endtask : t_mixed

	task automatic t_restore;
		restore_seen = 1'b0;
		do_reset(1'b1);
		check(restore_seen === 1'b1 && flash === 1'b1, "power-up restore missing");
		btn = 1'b0;
		repeat (3) @(negedge clk);
		check(flash === 1'b0, "flash not cleared");
	endtask : t_restore

	////////////////////////////////////////////////////////////////////////////
	initial begin
		do_reset(1'b0);
		t_idle;
		t_arm;
		t_cmd;
		t_ref;
		t_acc;
		t_grace;
		t_loss;
		t_mixed;
		t_restore;
		test_done;
	end

	// Run needs about 0.6 million cycles; cut off well beyond that
	initial begin
		#150_000_000;
		err_count++;
		$display("FAIL %0t watchdog expired", $time);
		test_done;
	end
endmodule : tb_rc_pulse_capture_watchdog
